// ===== design/perf_evt_pkg.sv
// Package: event codes, carriers and counter constants for event decode
// Behaviour
// - Code 0FH counts segment writes, descriptor table and task regs too.
// - Loads by load instrs, far transfers, task switches, interrupts count.
// - Far transfer or task switch changing privilege level counts twice.
// - Code 12H counts taken and not-taken branches of all listed kinds.
// - Serializing, verify, desc loads, interrupts, traps count as taken.
// - Branch count uses executed branches only, flush not required.
// - Code 13H counts target buffer hits of executed instructions only.
// - Code 14H counts OR of taken branch and target buffer hit.
// - Code 15H counts flushes: misses, mispredicts, exceptions, ints, loads.
// - Flush count ignores serializing instructions and software interrupts.
// - Code 16H counts executed instructions, up to two per clock, three with an interrupt or exception.
// - Fault handler calls, interrupts and exceptions count as instructions.
// - Repeated string instruction counts once regardless of iterations.
// - Halt instruction counts once regardless of halted cycles.
// - Code 17H counts instructions executed in the secondary pipe only.
// - Code 18H counts clocks with bus cycle, hold, address hold or backoff.
// - Code 19H counts clocks stalled because write buffers are full.
// - Stalls cover read misses, write misses, shared hits; not I/O.
package perf_evt_pkg;

  // ******************************************************************
  // Event codes
  // ******************************************************************
  localparam logic [5:0] EVT_SEG_LOAD   = 6'h0F;
  localparam logic [5:0] EVT_RSVD_A     = 6'h10;
  localparam logic [5:0] EVT_RSVD_B     = 6'h11;
  localparam logic [5:0] EVT_BRANCH     = 6'h12;
  localparam logic [5:0] EVT_TGT_HIT    = 6'h13;
  localparam logic [5:0] EVT_TAKEN_OR   = 6'h14;
  localparam logic [5:0] EVT_FLUSH      = 6'h15;
  localparam logic [5:0] EVT_INSTR      = 6'h16;
  localparam logic [5:0] EVT_INSTR_SEC  = 6'h17;
  localparam logic [5:0] EVT_BUS_BUSY   = 6'h18;
  localparam logic [5:0] EVT_WBUF_STALL = 6'h19;

  // ******************************************************************
  // Widths and reset values
  // ******************************************************************
  localparam int         CNT_W        = 40;
  localparam int         INC_W        = 3;
  localparam logic [39:0] CNT_RESET   = 40'h00_0000_0000;
  localparam logic [2:0] INC_ZERO     = 3'h0;

  // Per-pipe retirement info, one per pipe slot each clock
  typedef struct packed {
    logic valid;          // Instruction completes in this pipe
    logic is_branch;      // Branch class incl. sw interrupts, returns
    logic branch_taken;   // Actually taken at execute
    logic forced_taken;   // Serializing, verify, desc load, trap
    logic target_hit;     // Branch target buffer hit
    logic rep_iter_cont;  // Further repeat iteration, not counted
    logic seg_write;      // Explicit segment or table register write
  } pipe_retire_t;

  // Core-wide per-clock conditions
  typedef struct packed {
    logic far_xfer;        // Far transfer / task switch / int entry
    logic priv_change;     // That transfer changes privilege level
    logic hw_event;        // Hardware interrupt incl. flush request
    logic exception;       // Exception invoking a handler
    logic flush_miss;      // Flush: target miss on taken branch
    logic flush_mispred;   // Flush: misprediction
    logic flush_desc;      // Flush: segment descriptor load
    logic bus_cycle;       // Bus cycle in progress
    logic bus_hold_ack;    // Bus hold acknowledge clock
    logic addr_hold;       // Address hold request clock
    logic bus_backoff;     // Bus backoff clock
    logic wbuf_full_stall; // Pipe stalled on full write buffers
    logic stall_io;        // The stalled access is to I/O space
  } core_status_t;

  typedef struct packed {
    logic [5:0]       sel;
    logic             enable;
  } evt_cfg_t;

endpackage

// ===== design/perf_pipe_count.sv
// Per-pipe occurrence counts for one retirement slot
`timescale 1ns/1ps
module perf_pipe_count
  import perf_evt_pkg::*;
(
  // Slot
  input  wire pipe_retire_t p_in,
  // Counts
  output logic              instr_out,
  output logic              branch_out,
  output logic              hit_out,
  output logic              taken_or_hit_out,
  output logic              seg_out
);
  logic ex;
  assign ex               = p_in.valid && !p_in.rep_iter_cont;
  assign instr_out        = ex;
  assign branch_out       = ex && (p_in.is_branch || p_in.forced_taken);
  assign hit_out          = ex && p_in.target_hit;
  assign taken_or_hit_out = ex && ((p_in.is_branch && p_in.branch_taken)
                            || p_in.forced_taken || p_in.target_hit);
  assign seg_out          = ex && p_in.seg_write;
endmodule

// ===== design/perf_event_decode.sv
// Event selection and counter increment for codes 0FH to 19H
`timescale 1ns/1ps
module perf_event_decode
  import perf_evt_pkg::*;
#(
  parameter int CW = CNT_W
)
(
  // Clock and reset
  input  wire logic           clk_sys_in,
  input  wire logic           rst_in,
  // Configuration
  input  wire evt_cfg_t       cfg_in,
  input  wire logic           clear_in,
  // Core status
  input  wire pipe_retire_t   upipe_in,
  input  wire pipe_retire_t   vpipe_in,
  input  wire core_status_t   core_in,
  // Results
  output logic [CW-1:0]       count_out,
  output logic [INC_W-1:0]    inc_out
);

  // ******************************************************************
  // Per-pipe decode
  // ******************************************************************
  logic [1:0] instr_v;
  logic [1:0] branch_v;
  logic [1:0] hit_v;
  logic [1:0] toh_v;
  logic [1:0] seg_v;
  pipe_retire_t slots [2];
  assign slots[0] = upipe_in;
  assign slots[1] = vpipe_in;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_pipe
      perf_pipe_count u_cnt (
        .p_in             (slots[gi]),
        .instr_out        (instr_v[gi]),
        .branch_out       (branch_v[gi]),
        .hit_out          (hit_v[gi]),
        .taken_or_hit_out (toh_v[gi]),
        .seg_out          (seg_v[gi])
      );
    end
  endgenerate

  // ******************************************************************
  // State
  // ******************************************************************
  typedef struct packed {
    logic [CW-1:0]    count;
    logic [INC_W-1:0] inc;
  } state_t;

  state_t st_r;
  state_t st_nxt;
  logic [INC_W-1:0] inc_c;
  logic             evt_hw;
  logic             flush_c;
  logic [INC_W-1:0] seg_far;

  // Interrupt or exception counts as instruction and taken branch
  assign evt_hw  = core_in.hw_event || core_in.exception;
  // Software interrupts and serializing never flag a flush input
  assign flush_c = core_in.flush_miss || core_in.flush_mispred
                   || core_in.flush_desc || evt_hw;
  // Privilege change doubles the far-transfer load
  assign seg_far = core_in.far_xfer
                   ? (core_in.priv_change ? 3'h2 : 3'h1) : INC_ZERO;

  always_comb begin
    inc_c = INC_ZERO;
    unique case (cfg_in.sel)
      EVT_SEG_LOAD:
        inc_c = seg_far + {2'h0, seg_v[0]} + {2'h0, seg_v[1]};
      EVT_BRANCH:
        inc_c = {2'h0, branch_v[0]} + {2'h0, branch_v[1]}
                + {2'h0, evt_hw};
      EVT_TGT_HIT:
        inc_c = {2'h0, hit_v[0]} + {2'h0, hit_v[1]};
      EVT_TAKEN_OR:
        inc_c = {2'h0, toh_v[0]} + {2'h0, toh_v[1]};
      EVT_FLUSH:
        inc_c = {2'h0, flush_c};
      EVT_INSTR:
        inc_c = {2'h0, instr_v[0]} + {2'h0, instr_v[1]}
                + {2'h0, evt_hw};
      EVT_INSTR_SEC:
        inc_c = {2'h0, instr_v[1]};
      EVT_BUS_BUSY:
        inc_c = {2'h0, core_in.bus_cycle || core_in.bus_hold_ack
                 || core_in.addr_hold || core_in.bus_backoff};
      EVT_WBUF_STALL:
        inc_c = {2'h0, core_in.wbuf_full_stall
                 && !core_in.stall_io};
      default:
        inc_c = INC_ZERO;
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.inc = cfg_in.enable ? inc_c : INC_ZERO;
    if (clear_in) begin
      st_nxt.count = CNT_RESET[CW-1:0];
    end else if (cfg_in.enable) begin
      st_nxt.count = st_r.count + {{(CW-INC_W){1'b0}}, inc_c};
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      st_r <= '{count: CNT_RESET[CW-1:0], inc: INC_ZERO};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign count_out = st_r.count;
  assign inc_out   = st_r.inc;

  // ******************************************************************
  // Checks
  // ******************************************************************
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  chk_count_adds: assert property (
    !clear_in && cfg_in.enable |=> count_out == $past(count_out)
      + {{(CW-INC_W){1'b0}}, $past(inc_c)})
    else $error("counter did not add increment");
  chk_reserved_hold: assert property (
    (cfg_in.sel == EVT_RSVD_A || cfg_in.sel == EVT_RSVD_B) && !clear_in
      |=> count_out == $past(count_out))
    else $error("reserved code changed counter");
  chk_priv_double: assert property (
    cfg_in.sel == EVT_SEG_LOAD && core_in.far_xfer && core_in.priv_change
      |-> inc_c >= 3'h2)
    else $error("privilege change not counted twice");
  chk_instr_max: assert property (
    cfg_in.sel == EVT_INSTR && !evt_hw |-> inc_c <= 3'h2)
    else $error("more than two instructions per clock");
  chk_rep_once: assert property (
    cfg_in.sel == EVT_INSTR && !evt_hw && upipe_in.rep_iter_cont
      && !vpipe_in.valid |-> inc_c == INC_ZERO)
    else $error("repeat iteration counted");
  chk_sec_only: assert property (
    cfg_in.sel == EVT_INSTR_SEC && !vpipe_in.valid |-> inc_c == INC_ZERO)
    else $error("primary pipe counted as secondary");
  chk_bus_clock: assert property (
    cfg_in.sel == EVT_BUS_BUSY && cfg_in.enable && core_in.bus_backoff
      |=> inc_out == 3'h1)
    else $error("backoff clock not counted");
  chk_wbuf_io: assert property (
    cfg_in.sel == EVT_WBUF_STALL && core_in.stall_io |-> inc_c == INC_ZERO)
    else $error("io stall counted");
  chk_hit_exec: assert property (
    cfg_in.sel == EVT_TGT_HIT && !upipe_in.valid && !vpipe_in.valid
      |-> inc_c == INC_ZERO)
    else $error("hit without execution counted");
  chk_clear_zero: assert property (
    clear_in |=> count_out == '0)
    else $error("clear did not zero counter");
  // Disabled counter must hold, else software reads drift
  chk_disabled_hold: assert property (
    !cfg_in.enable && !clear_in |=> count_out == $past(count_out))
    else $error("disabled counter changed");
  chk_disabled_inc: assert property (
    !cfg_in.enable |=> inc_out == INC_ZERO)
    else $error("increment shown while disabled");
  chk_seg_single: assert property (
    cfg_in.sel == EVT_SEG_LOAD && core_in.far_xfer && !core_in.priv_change
      && !upipe_in.seg_write && !vpipe_in.seg_write |-> inc_c == 3'h1)
    else $error("far transfer load not counted once");
  chk_branch_nt: assert property (
    cfg_in.sel == EVT_BRANCH && upipe_in.valid && upipe_in.is_branch
      && !upipe_in.branch_taken && !vpipe_in.valid && !evt_hw
      |-> inc_c == 3'h1)
    else $error("not-taken branch not counted");
  chk_branch_exec: assert property (
    cfg_in.sel == EVT_BRANCH && !upipe_in.valid && !vpipe_in.valid
      && !evt_hw |-> inc_c == INC_ZERO)
    else $error("branch counted without execution");
  chk_toh_hit: assert property (
    cfg_in.sel == EVT_TAKEN_OR && upipe_in.valid && upipe_in.target_hit
      && !upipe_in.rep_iter_cont && !vpipe_in.valid |-> inc_c == 3'h1)
    else $error("target hit not counted in taken-or-hit");
  chk_flush_one: assert property (
    cfg_in.sel == EVT_FLUSH && core_in.flush_miss |-> inc_c == 3'h1)
    else $error("flush not counted once");
  chk_flush_quiet: assert property (
    cfg_in.sel == EVT_FLUSH && !core_in.flush_miss && !core_in.flush_mispred
      && !core_in.flush_desc && !evt_hw |-> inc_c == INC_ZERO)
    else $error("flush counted without a flush source");
  chk_hw_instr: assert property (
    cfg_in.sel == EVT_INSTR && core_in.exception && !upipe_in.valid
      && !vpipe_in.valid |-> inc_c == 3'h1)
    else $error("exception not counted as instruction");
  chk_bus_idle: assert property (
    cfg_in.sel == EVT_BUS_BUSY && !core_in.bus_cycle && !core_in.bus_hold_ack
      && !core_in.addr_hold && !core_in.bus_backoff |-> inc_c == INC_ZERO)
    else $error("idle bus clock counted");
  chk_wbuf_count: assert property (
    cfg_in.sel == EVT_WBUF_STALL && core_in.wbuf_full_stall
      && !core_in.stall_io |-> inc_c == 3'h1)
    else $error("write buffer stall clock not counted");

  cov_seg_double: cover property (
    cfg_in.sel == EVT_SEG_LOAD && inc_c == 3'h2);
  cov_two_instr: cover property (
    cfg_in.sel == EVT_INSTR && inc_c == 3'h2);
  cov_flush: cover property (cfg_in.sel == EVT_FLUSH && flush_c);
  cov_stall_run: cover property (
    (cfg_in.sel == EVT_WBUF_STALL && core_in.wbuf_full_stall) [*3]);

endmodule

// ===== tb/perf_event_decode_tb_top.sv
// Self-checking bench for the event decode and counter block
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin mismatches++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
module perf_event_decode_tb_top;
  import perf_evt_pkg::*;
  logic             clk_sys_in = 1'h0;
  logic             rst_in     = 1'h1;
  logic             clear_in   = 1'h0;
  evt_cfg_t         cfg        = '0;
  pipe_retire_t     up         = '0;
  pipe_retire_t     vp         = '0;
  core_status_t     cs         = '0;
  logic [CNT_W-1:0] count_out;
  logic [INC_W-1:0] inc_out;
  logic [CNT_W-1:0] exp_cnt    = '0;
  int               mismatches = 0;
  int               checks     = 0;

  always #12.5 clk_sys_in = ~clk_sys_in;

  perf_event_decode dut_u (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .cfg_in     (cfg),
    .clear_in   (clear_in),
    .upipe_in   (up),
    .vpipe_in   (vp),
    .core_in    (cs),
    .count_out  (count_out),
    .inc_out    (inc_out)
  );

  // ****************************************************************
  // Shared steps
  // ****************************************************************
  task automatic tally_and_finish();
    if (mismatches == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic idle();
    up = '0;
    vp = '0;
    cs = '0;
  endtask

  // One counting clock; inputs set by caller at the falling edge
  task automatic cyc(input logic [5:0] sel, input logic [2:0] e);
    cfg.sel    = sel;
    cfg.enable = 1'h1;
    @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    exp_cnt = exp_cnt + CNT_W'(e);
    `CHK(inc_out, e)
    `CHK(count_out, exp_cnt)
    idle();
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic seg_loads();
    up.valid = 1'h1; up.seg_write = 1'h1; vp.valid = 1'h1;
    vp.seg_write = 1'h1; cs.far_xfer = 1'h1; cs.priv_change = 1'h1;
    cyc(EVT_SEG_LOAD, 3'h4);
    cs.far_xfer = 1'h1;
    cyc(EVT_SEG_LOAD, 3'h1);
  endtask

  task automatic branches();
    up.valid = 1'h1; up.is_branch = 1'h1; vp.valid = 1'h1;
    vp.forced_taken = 1'h1; cs.hw_event = 1'h1;
    cyc(EVT_BRANCH, 3'h3);
    up.valid = 1'h1; up.is_branch = 1'h1; up.branch_taken = 1'h1;
    vp.is_branch = 1'h1; cs.exception = 1'h1;
    cyc(EVT_BRANCH, 3'h2);
  endtask

  task automatic target_hits();
    up.valid = 1'h1; up.target_hit = 1'h1; vp.target_hit = 1'h1;
    cyc(EVT_TGT_HIT, 3'h1);
    up.valid = 1'h1; up.is_branch = 1'h1; up.branch_taken = 1'h1;
    up.target_hit = 1'h1; vp.valid = 1'h1; vp.forced_taken = 1'h1;
    cyc(EVT_TAKEN_OR, 3'h2);
    vp.valid = 1'h1; vp.is_branch = 1'h1;
    cyc(EVT_TAKEN_OR, 3'h0);
  endtask

  task automatic flushes();
    cs.flush_miss = 1'h1; cs.flush_mispred = 1'h1; cs.exception = 1'h1;
    cyc(EVT_FLUSH, 3'h1);
    cs.flush_desc = 1'h1;
    cyc(EVT_FLUSH, 3'h1);
    up.valid = 1'h1; up.forced_taken = 1'h1; vp.valid = 1'h1;
    vp.is_branch = 1'h1;
    cyc(EVT_FLUSH, 3'h0);
  endtask

  task automatic instructions();
    up.valid = 1'h1; vp.valid = 1'h1;
    cyc(EVT_INSTR, 3'h2);
    up.valid = 1'h1; up.rep_iter_cont = 1'h1; vp.valid = 1'h1;
    cyc(EVT_INSTR, 3'h1);
    cs.exception = 1'h1;
    cyc(EVT_INSTR, 3'h1);
    up.valid = 1'h1;
    cyc(EVT_INSTR, 3'h1);
    cyc(EVT_INSTR, 3'h0);
    up.valid = 1'h1; vp.valid = 1'h1;
    cyc(EVT_INSTR_SEC, 3'h1);
  endtask

  // Bus cycle, hold ack, address hold alone, then backoff with bus cycle still one clock
  task automatic bus_and_stall();
    cs.bus_cycle = 1'h1;
    cyc(EVT_BUS_BUSY, 3'h1);
    cs.bus_hold_ack = 1'h1;
    cyc(EVT_BUS_BUSY, 3'h1);
    cs.addr_hold = 1'h1;
    cyc(EVT_BUS_BUSY, 3'h1);
    cs.bus_backoff = 1'h1; cs.bus_cycle = 1'h1;
    cyc(EVT_BUS_BUSY, 3'h1);
    cs.wbuf_full_stall = 1'h1;
    cyc(EVT_WBUF_STALL, 3'h1);
    cs.wbuf_full_stall = 1'h1; cs.stall_io = 1'h1;
    cyc(EVT_WBUF_STALL, 3'h0);
  endtask

  task automatic reserved_and_ctrl();
    up = '1; vp = '1; cs = '1;
    cyc(EVT_RSVD_A, 3'h0);
    up = '1; vp = '1; cs = '1;
    cyc(EVT_RSVD_B, 3'h0);
    up.valid = 1'h1; cfg.enable = 1'h0; cfg.sel = EVT_INSTR;
    @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    `CHK(inc_out, INC_ZERO)
    `CHK(count_out, exp_cnt)
    clear_in = 1'h1;
    @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    clear_in = 1'h0;
    exp_cnt = CNT_RESET;
    `CHK(count_out, exp_cnt)
    idle();
  endtask

  // Reset mid-run with events pending clears both outputs
  task automatic mid_reset();
    up.valid   = 1'h1;
    vp.valid   = 1'h1;
    cfg.sel    = EVT_INSTR;
    cfg.enable = 1'h1;
    rst_in     = 1'h1;
    @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    `CHK(count_out, CNT_RESET)
    `CHK(inc_out, INC_ZERO)
    rst_in  = 1'h0;
    exp_cnt = CNT_RESET;
    cyc(EVT_INSTR, 3'h2);
  endtask

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial begin
    repeat (5) @(negedge clk_sys_in);
    rst_in = 1'h0;
    `CHK(count_out, CNT_RESET)
    `CHK(inc_out, INC_ZERO)
    seg_loads();
    branches();
    target_hits();
    flushes();
    instructions();
    bus_and_stall();
    mid_reset();
    reserved_and_ctrl();
    tally_and_finish();
  end

  // Bounded run; a hang counts as a failure
  initial begin
    repeat (5000) @(posedge clk_sys_in);
    mismatches++;
    tally_and_finish();
  end
endmodule
